// ==== pmc_pkg.sv ====
package pmc_pkg;
   // clock and internal timebase
   localparam int CLK_PERIOD_NS = 10;
   localparam int TB_PERIOD_NS = 1000;
   localparam int TB_CYCLES = (TB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] TB_LAST = 8'(TB_CYCLES - 1);
   // sample rates in timebase ticks
   localparam int SAMPLE_DIV_DEF = 10000;
   localparam int WAKE_DIV_DEF = 166667;
   // register offsets
   localparam logic [7:0] OFS_INACT_TIME_L = 8'h25;
   localparam logic [7:0] OFS_INACT_TIME_H = 8'h26;
   localparam logic [7:0] OFS_MOTION_CFG = 8'h27;
   localparam logic [7:0] OFS_IRQ_MAP_ONE = 8'h2a;
   localparam logic [7:0] OFS_IRQ_MAP_TWO = 8'h2b;
   localparam logic [7:0] OFS_POWER = 8'h2d;
   localparam logic [7:0] OFS_FORCE_CHECK = 8'h2e;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h31;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h32;
   // field positions
   localparam int MDC_LINK_POS = 4;
   localparam int FORCE_POS = 0;
   localparam int EV_DOZE_POS = 0;
   localparam int EV_WOKE_POS = 1;
   localparam int EV_START_POS = 2;
   localparam int EV_W = 3;
   // reset values
   localparam logic [7:0] PWR_RESET = 8'h00;
   localparam logic [7:0] FORCE_RESET = 8'h00;
   localparam logic [7:0] MDC_RESET = 8'h00;
   localparam logic [7:0] MAP_RESET = 8'h00;
   localparam logic [15:0] INACT_RESET = 16'h0000;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
   // run-state and noise codes
   localparam logic [1:0] RUN_STANDBY = 2'h0;
   localparam logic [1:0] RUN_RUN_STATE_SELECT = 2'h2;
   typedef enum logic [1:0] {
      PMC_NOISE_NORMAL = 2'h0,
      PMC_NOISE_LOW = 2'h1,
      PMC_NOISE_ULTRA = 2'h2
   } pmc_noise_t;
   localparam logic [1:0] NOISE_RSV = 2'h3;
   // operating state, gray along idle, run, doze
   typedef enum logic [1:0] {
      PMC_ST_IDLE = 2'h0,
      PMC_ST_RUN = 2'h1,
      PMC_ST_DOZE = 2'h3
   } pmc_state_t;
   // power register layout
   typedef struct packed {
      logic rsv;
      logic ext_tb;
      logic [1:0] noise;
      logic wake_cycle;
      logic auto_doze;
      logic [1:0] run;
   } pmc_power_t;
   // interrupt pin map layout
   typedef struct packed {
      logic act_low;
      logic [6:0] fmap;
   } pmc_map_t;
endpackage

// ==== pmc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
   parameter int W = 1
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // asynchronous level and its synchronised copy
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // two flops; only the second reads the first
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else if (ce_in)
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// ==== pmc_irq_pin.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_irq_pin (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // configuration and function levels
   input wire pmc_pkg::pmc_map_t map_in,
   input wire logic inhibit_in,
   input wire logic [6:0] func_in,
   // pin drive
   output logic pin_out,
   output logic pin_oe_out
);
   logic pin_q;
   logic oe_q;

   // mapped functions are or'ed; unmapped pin floats
   wire any_mapped = |map_in.fmap;
   wire hit = |(map_in.fmap & func_in);
   wire pol_low = map_in.act_low;

   // register level and enable
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         pin_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (ce_in)
      begin
         pin_q <= hit ^ pol_low;
         oe_q <= any_mapped && !inhibit_in;
      end
   end

   assign pin_out = pin_q;
   assign pin_oe_out = oe_q;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   chk_pin_polarity: assert property (ce_in ##1 ce_in |-> pin_out == ($past(hit) ^ $past(pol_low)))
      else $error("irq pin level does not follow polarity");
   chk_pin_float: assert property (ce_in && !any_mapped |=> !pin_oe_out)
      else $error("irq pin driven with nothing mapped");
endmodule
`default_nettype wire

// ==== pmc_power_mode_control.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_control #(
   parameter int SAMPLE_DIV = pmc_pkg::SAMPLE_DIV_DEF,
   parameter int WAKE_DIV = pmc_pkg::WAKE_DIV_DEF
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // motion detection levels
   input wire logic inactive_in,
   input wire logic active_in,
   input wire logic [5:0] func_status_in,
   // interrupt pins
   input wire logic irq_pin_one_in,
   output logic irq_pin_one_out,
   output logic irq_pin_one_oe_out,
   output logic irq_pin_two_out,
   output logic irq_pin_two_oe_out,
   // mode outputs
   output logic run_active_out,
   output pmc_pkg::pmc_noise_t noise_mode_out,
   output logic wake_mode_out,
   output logic awake_out,
   output logic [2:0] force_check_out,
   output logic sample_tick_out,
   output logic irq_out
);
   // register file
   pmc_pkg::pmc_power_t pwr_q;
   logic [7:0] force_q;
   logic [7:0] mdc_q;
   logic [15:0] inact_time_q;
   pmc_pkg::pmc_map_t map_one_q;
   pmc_pkg::pmc_map_t map_two_q;
   logic [pmc_pkg::EV_W-1:0] sts_q;
   logic [pmc_pkg::EV_W-1:0] ien_q;
   logic [7:0] rdata_q;
   // timing and state
   pmc_pkg::pmc_state_t state_q;
   pmc_pkg::pmc_state_t state_d;
   logic [7:0] tb_cnt_q;
   logic [19:0] smp_cnt_q;
   logic [15:0] inact_cnt_q;
   logic pin_prev_q;
   logic pin_sync;
   // registered outputs
   logic run_q;
   pmc_pkg::pmc_noise_t noise_q;
   logic wake_q;
   logic awake_q;
   logic tick_q;
   logic irq_q;

   localparam logic [19:0] SAMPLE_LAST = 20'(SAMPLE_DIV - 1);
   localparam logic [19:0] WAKE_LAST = 20'(WAKE_DIV - 1);

   // write decode
   wire wr_pwr = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_POWER);
   wire wr_force = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_FORCE_CHECK);
   wire wr_mdc = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_MOTION_CFG);
   wire wr_itl = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_INACT_TIME_L);
   wire wr_ith = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_INACT_TIME_H);
   wire wr_map1 = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_IRQ_MAP_ONE);
   wire wr_map2 = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_IRQ_MAP_TWO);
   wire wr_clr = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_IRQ_CLEAR);
   wire wr_ien = reg_wr_in && (reg_addr_in == pmc_pkg::OFS_IRQ_ENABLE);

   // read selection, unmapped and write-only offsets read zero
   wire [7:0] rd_mux =
      (reg_addr_in == pmc_pkg::OFS_POWER) ? pwr_q :
      (reg_addr_in == pmc_pkg::OFS_FORCE_CHECK) ? force_q :
      (reg_addr_in == pmc_pkg::OFS_MOTION_CFG) ? mdc_q :
      (reg_addr_in == pmc_pkg::OFS_INACT_TIME_L) ? inact_time_q[7:0] :
      (reg_addr_in == pmc_pkg::OFS_INACT_TIME_H) ? inact_time_q[15:8] :
      (reg_addr_in == pmc_pkg::OFS_IRQ_MAP_ONE) ? map_one_q :
      (reg_addr_in == pmc_pkg::OFS_IRQ_MAP_TWO) ? map_two_q :
      (reg_addr_in == pmc_pkg::OFS_IRQ_STATUS) ? {5'h00, sts_q} :
      (reg_addr_in == pmc_pkg::OFS_IRQ_ENABLE) ? {5'h00, ien_q} :
      pmc_pkg::RDATA_IDLE;
   wire [7:0] rdata_d = reg_rd_in ? rd_mux : pmc_pkg::RDATA_IDLE;

   // configuration registers
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         pwr_q <= pmc_pkg::PWR_RESET;
         force_q <= pmc_pkg::FORCE_RESET;
         mdc_q <= pmc_pkg::MDC_RESET;
         inact_time_q <= pmc_pkg::INACT_RESET;
         map_one_q <= pmc_pkg::MAP_RESET;
         map_two_q <= pmc_pkg::MAP_RESET;
      end
      else if (ce_in)
      begin
         if (wr_pwr) pwr_q <= reg_wdata_in;
         if (wr_force) force_q <= reg_wdata_in;
         if (wr_mdc) mdc_q <= reg_wdata_in;
         if (wr_itl) inact_time_q[7:0] <= reg_wdata_in;
         if (wr_ith) inact_time_q[15:8] <= reg_wdata_in;
         if (wr_map1) map_one_q <= reg_wdata_in;
         if (wr_map2) map_two_q <= reg_wdata_in;
      end
   end

   // read data stands for the one cycle after the strobe
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         rdata_q <= pmc_pkg::RDATA_IDLE;
      else if (ce_in)
         rdata_q <= rdata_d;
   end

   // field decode
   wire run_meas = (pwr_q.run == pmc_pkg::RUN_RUN_STATE_SELECT);
   wire ext_sel = pwr_q.ext_tb;
   wire doze_ok = pwr_q.auto_doze && mdc_q[pmc_pkg::MDC_LINK_POS];
   wire inact_hit = inactive_in && (inact_cnt_q >= inact_time_q);
   // reserved noise code falls back to normal
   wire [1:0] noise_code = (pwr_q.noise == pmc_pkg::NOISE_RSV) ? 2'(pmc_pkg::PMC_NOISE_NORMAL) : pwr_q.noise;

   // external timebase pin passes two flops first
   pmc_sync #(
      .W(1)
   ) u_pin_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .async_in(irq_pin_one_in),
      .sync_out(pin_sync)
   );

   wire pin_rise = pin_sync && !pin_prev_q;
   wire int_tick = (tb_cnt_q == pmc_pkg::TB_LAST);
   wire tb_tick = ext_sel ? pin_rise : int_tick;

   // internal oscillator divider and pin edge history
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         tb_cnt_q <= 8'h00;
         pin_prev_q <= 1'b0;
      end
      else if (ce_in)
      begin
         tb_cnt_q <= int_tick ? 8'h00 : tb_cnt_q + 8'h01;
         pin_prev_q <= pin_sync;
      end
   end

   // operating state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         pmc_pkg::PMC_ST_IDLE:
            if (run_meas) state_d = pmc_pkg::PMC_ST_RUN;
         pmc_pkg::PMC_ST_RUN:
            if (!run_meas) state_d = pmc_pkg::PMC_ST_IDLE;
            else if (doze_ok && inact_hit) state_d = pmc_pkg::PMC_ST_DOZE;
         pmc_pkg::PMC_ST_DOZE:
            if (!run_meas) state_d = pmc_pkg::PMC_ST_IDLE;
            else if (!doze_ok || active_in) state_d = pmc_pkg::PMC_ST_RUN;
         default:
            state_d = pmc_pkg::PMC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         state_q <= pmc_pkg::PMC_ST_IDLE;
      else if (ce_in)
         state_q <= state_d;
   end

   // sample pacing, slow in wake-up or doze
   wire running = (state_q != pmc_pkg::PMC_ST_IDLE);
   wire dozing = (state_q == pmc_pkg::PMC_ST_DOZE);
   wire wake_mode = running && (pwr_q.wake_cycle || dozing);
   wire [19:0] smp_last = wake_mode ? WAKE_LAST : SAMPLE_LAST;
   wire smp_wrap = (smp_cnt_q >= smp_last);
   wire smp_tick = running && tb_tick && smp_wrap;

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         smp_cnt_q <= 20'h0_0000;
      else if (ce_in)
      begin
         if (!running) smp_cnt_q <= 20'h0_0000;
         else if (tb_tick) smp_cnt_q <= smp_wrap ? 20'h0_0000 : smp_cnt_q + 20'h0_0001;
      end
   end

   // inactivity timer counts samples at the current rate
   wire inact_max = (inact_cnt_q == 16'hffff);
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         inact_cnt_q <= 16'h0000;
      else if (ce_in)
      begin
         if (!inactive_in || !running) inact_cnt_q <= 16'h0000;
         else if (smp_tick && !inact_max) inact_cnt_q <= inact_cnt_q + 16'h0001;
      end
   end

   // events into sticky status, a set beats a clear
   wire [pmc_pkg::EV_W-1:0] ev;
   assign ev[pmc_pkg::EV_DOZE_POS] = (state_q == pmc_pkg::PMC_ST_RUN) && (state_d == pmc_pkg::PMC_ST_DOZE);
   assign ev[pmc_pkg::EV_WOKE_POS] = dozing && (state_d == pmc_pkg::PMC_ST_RUN);
   assign ev[pmc_pkg::EV_START_POS] = !running && (state_d == pmc_pkg::PMC_ST_RUN);
   wire [pmc_pkg::EV_W-1:0] clr = wr_clr ? reg_wdata_in[pmc_pkg::EV_W-1:0] : '0;
   wire [pmc_pkg::EV_W-1:0] sts_d = (sts_q & ~clr) | ev;

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         sts_q <= '0;
         ien_q <= '0;
      end
      else if (ce_in)
      begin
         sts_q <= sts_d;
         if (wr_ien) ien_q <= reg_wdata_in[pmc_pkg::EV_W-1:0];
      end
   end

   // registered mode outputs
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         run_q <= 1'b0;
         noise_q <= pmc_pkg::PMC_NOISE_NORMAL;
         wake_q <= 1'b0;
         awake_q <= 1'b0;
         tick_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else if (ce_in)
      begin
         run_q <= running;
         noise_q <= pmc_pkg::pmc_noise_t'(noise_code);
         wake_q <= wake_mode;
         awake_q <= (state_q == pmc_pkg::PMC_ST_RUN);
         tick_q <= smp_tick;
         irq_q <= |(sts_d & ien_q);
      end
   end

   // interrupt pins, pin one released while it is the timebase
   wire [6:0] func_vec = {awake_q, func_status_in};
   pmc_irq_pin u_pin_one (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .map_in(map_one_q),
      .inhibit_in(ext_sel),
      .func_in(func_vec),
      .pin_out(irq_pin_one_out),
      .pin_oe_out(irq_pin_one_oe_out)
   );
   pmc_irq_pin u_pin_two (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .map_in(map_two_q),
      .inhibit_in(1'b0),
      .func_in(func_vec),
      .pin_out(irq_pin_two_out),
      .pin_oe_out(irq_pin_two_oe_out)
   );

   // outputs
   assign reg_rdata_out = rdata_q;
   assign run_active_out = run_q;
   assign noise_mode_out = noise_q;
   assign wake_mode_out = wake_q;
   assign awake_out = awake_q;
   assign force_check_out = {3{force_q[pmc_pkg::FORCE_POS]}};
   assign sample_tick_out = tick_q;
   assign irq_out = irq_q;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_doze_cause;
      ce_in && state_q == pmc_pkg::PMC_ST_RUN && run_meas && doze_ok && inact_hit;
   endsequence
   sequence s_doze_seen;
      state_q == pmc_pkg::PMC_ST_DOZE && sts_q[pmc_pkg::EV_DOZE_POS] ##1 !awake_q;
   endsequence

   chk_standby_idle: assert property (ce_in && pwr_q.run == pmc_pkg::RUN_STANDBY |=> !running ##0 !smp_tick)
      else $error("standby code did not stop measurement");
   chk_run_state_select_start: assert property (ce_in && !running && run_meas |=>
      state_q == pmc_pkg::PMC_ST_RUN ##0 (!ce_in or (1'b1 ##1 run_active_out)))
      else $error("measurement code did not start measurement");
   chk_noise_decode: assert property (ce_in && pwr_q.noise == 2'h2 |=> noise_mode_out == pmc_pkg::PMC_NOISE_ULTRA)
      else $error("ultralow noise code not decoded");
   chk_noise_reserved: assert property (ce_in && pwr_q.noise == pmc_pkg::NOISE_RSV |=> noise_mode_out == pmc_pkg::PMC_NOISE_NORMAL)
      else $error("reserved noise code not treated as normal");
   chk_ext_timebase: assert property (ext_sel && !pin_rise |-> !tb_tick ##0 !smp_tick)
      else $error("timebase ticked without a pin edge");
   chk_ext_release: assert property (ce_in && ext_sel |=> !irq_pin_one_oe_out)
      else $error("pin one driven while used as timebase");
   chk_wake_rate: assert property (ce_in && pwr_q.wake_cycle && running |-> smp_last == WAKE_LAST)
      else $error("wake-up mode not using the slow rate");
   chk_doze_ignored: assert property (ce_in && !doze_ok |=> state_q != pmc_pkg::PMC_ST_DOZE)
      else $error("auto-doze acted outside linked or loop mode");
   chk_doze_entry: assert property (s_doze_cause |=> s_doze_seen or (!ce_in ##1 1'b1))
      else $error("inactivity did not put the device into doze");
   chk_force_axes: assert property (ce_in && wr_force && reg_wdata_in[0] |=> force_check_out == 3'h7)
      else $error("test force not applied to all axes");
   chk_force_clear: assert property (ce_in && wr_force && !reg_wdata_in[0] |=> force_check_out == 3'h0)
      else $error("test force not removed");
   chk_inact_count: assert property (ce_in && smp_tick && inactive_in && !inact_max |=> inact_cnt_q == $past(inact_cnt_q) + 16'h0001)
      else $error("inactivity timer missed a sample");
   chk_set_wins: assert property (ce_in && ev[pmc_pkg::EV_DOZE_POS] && clr[pmc_pkg::EV_DOZE_POS] |=> sts_q[pmc_pkg::EV_DOZE_POS])
      else $error("event lost to a simultaneous clear");
endmodule
`default_nettype wire

// ==== pmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
   // clock
   input wire logic clk_in,
   // register port toward the block
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   input wire logic [7:0] reg_rdata_in
);
   // quiet bus at time zero
   initial
   begin
      reg_addr_out = 8'hff;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end

   // one write cycle, then an idle cycle; address and data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
      @(posedge clk_in);
   endtask

   // one read cycle; data taken while it stands in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      #1;
      d = reg_rdata_in;
      @(posedge clk_in);
   endtask

   // power writes keep the spare top bit clear
   task automatic power(input logic [7:0] d);
      wr(pmc_pkg::OFS_POWER, d & 8'h7f);
   endtask

   // motion switch start-up: timers, motion config, map two, power register last
   task automatic motion_start(input logic [7:0] t);
      wr(pmc_pkg::OFS_INACT_TIME_L, t);
      wr(pmc_pkg::OFS_INACT_TIME_H, 8'h00);
      wr(pmc_pkg::OFS_MOTION_CFG, 8'h3f); // (hold count left to the detector)
      wr(pmc_pkg::OFS_IRQ_MAP_TWO, 8'h40);
      power(8'h0a);
   endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic ce_in;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd;
   logic inactive_in = 1'b0;
   logic active_in = 1'b0;
   logic [5:0] func_status_in = 6'h00;
   logic pin_one = 1'b0;
   logic ext_on = 1'b0;
   logic p1_out, p1_oe, p2_out, p2_oe, run_active, wake_mode, awake, tick, irq;
   logic [2:0] force_chk;
   pmc_pkg::pmc_noise_t noise_mode;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   int k;

   // 100 MHz clock
   always #5 clk_in = ~clk_in;

   pmc_host_model i_host (.clk_in(clk_in), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
      .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_rdata_in(reg_rdata));

   pmc_power_mode_control #(.SAMPLE_DIV(4), .WAKE_DIV(8)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .ce_in(ce_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .inactive_in(inactive_in), .active_in(active_in),
      .func_status_in(func_status_in), .irq_pin_one_in(pin_one), .irq_pin_one_out(p1_out),
      .irq_pin_one_oe_out(p1_oe), .irq_pin_two_out(p2_out), .irq_pin_two_oe_out(p2_oe),
      .run_active_out(run_active), .noise_mode_out(noise_mode), .wake_mode_out(wake_mode),
      .awake_out(awake), .force_check_out(force_chk), .sample_tick_out(tick), .irq_out(irq));

   // external timebase: a rising edge every 20 cycles while enabled, still otherwise
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (ext_on && (cyc % 10 == 0))
         pin_one <= ~pin_one;
      if (cyc == 20000)
      begin
         err_count++;
         finish_test();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_host.rd(a, d);
      check(what, d, exp);
   endtask

   task automatic settle();
      repeat (3) @(posedge clk_in);
   endtask

   // cycles between two sample pulses, seen on falling edges where outputs are settled
   task automatic period(output int p);
      int w;
      w = 0;
      while (tick !== 1'b1 && w < 4000)
      begin
         @(negedge clk_in);
         w++;
      end
      @(negedge clk_in);
      p = 1;
      while (tick !== 1'b1 && p < 4000)
      begin
         @(negedge clk_in);
         p++;
      end
      @(posedge clk_in);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      ce_in <= 1'b1;
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      // reset values, unmapped and write-only places
      rchk("power reset", pmc_pkg::OFS_POWER, pmc_pkg::PWR_RESET);
      rchk("force reset", pmc_pkg::OFS_FORCE_CHECK, pmc_pkg::FORCE_RESET);
      i_host.wr(8'h40, 8'hff);
      rchk("unmapped", 8'h40, 8'h00);
      rchk("clear reads zero", pmc_pkg::OFS_IRQ_CLEAR, 8'h00);
      check("run at reset", {7'h00, run_active}, 8'h00);
      $display("test reset done");
      // force check on all three axes, then off
      i_host.wr(pmc_pkg::OFS_FORCE_CHECK, 8'h01);
      check("force on", {5'h00, force_chk}, 8'h07);
      rchk("force readback", pmc_pkg::OFS_FORCE_CHECK, 8'h01);
      i_host.wr(pmc_pkg::OFS_FORCE_CHECK, 8'h00);
      check("force off", {5'h00, force_chk}, 8'h00);
      // a write offered while the clock enable is low must not land
      ce_in <= 1'b0;
      i_host.wr(pmc_pkg::OFS_FORCE_CHECK, 8'h01);
      ce_in <= 1'b1;
      check("frozen write", {5'h00, force_chk}, 8'h00);
      rchk("frozen readback", pmc_pkg::OFS_FORCE_CHECK, 8'h00);
      $display("test force done");
      // every run-state and noise code, reserved ones too
      for (int i = 0; i < 4; i++)
      begin
         i_host.wr(pmc_pkg::OFS_POWER, {2'b00, 2'(i), 2'b00, 2'(i)});
         settle();
         check("run state", {7'h00, run_active}, {7'h00, 1'(i == 2)});
         check("noise mode", {6'h00, noise_mode}, (i == 3) ? 8'h00 : 8'(i));
         rchk("power readback", pmc_pkg::OFS_POWER, {2'b00, 2'(i), 2'b00, 2'(i)});
      end
      $display("test codes done");
      // motion switch start-up: wake-up mode, awake on pin two
      i_host.motion_start(8'h1e);
      settle();
      check("wake mode", {7'h00, wake_mode}, 8'h01);
      check("awake", {7'h00, awake}, 8'h01);
      check("pin two high", {6'h00, p2_oe, p2_out}, 8'h03);
      period(n);
      check("wake rate", 8'(n / 100), 8'h08);
      i_host.wr(pmc_pkg::OFS_IRQ_MAP_TWO, 8'hc0);
      settle();
      check("pin two low", {6'h00, p2_oe, p2_out}, 8'h02);
      func_status_in <= 6'h01;
      i_host.wr(pmc_pkg::OFS_IRQ_MAP_ONE, 8'h01);
      settle();
      check("pin one high", {6'h00, p1_oe, p1_out}, 8'h03);
      i_host.wr(pmc_pkg::OFS_IRQ_MAP_ONE, 8'h81);
      settle();
      check("pin one low", {6'h00, p1_oe, p1_out}, 8'h02);
      $display("test motion switch done");
      // external timebase on pin one
      ext_on <= 1'b1;
      i_host.power(8'h42);
      settle();
      check("pin one released", {7'h00, p1_oe}, 8'h00);
      period(n);
      period(n);
      check("external rate", 8'(n), 8'h50);
      ext_on <= 1'b0;
      i_host.power(8'h02);
      period(n);
      period(n);
      check("internal rate", 8'(n / 100), 8'h04);
      $display("test timebase done");
      // auto-doze ignored without link mode, honored with it
      i_host.wr(pmc_pkg::OFS_IRQ_MAP_ONE, 8'h00);
      i_host.wr(pmc_pkg::OFS_INACT_TIME_L, 8'h02);
      i_host.wr(pmc_pkg::OFS_MOTION_CFG, 8'h00);
      i_host.wr(pmc_pkg::OFS_IRQ_CLEAR, 8'h07);
      i_host.wr(pmc_pkg::OFS_IRQ_ENABLE, 8'h01);
      i_host.power(8'h06);
      inactive_in <= 1'b1;
      repeat (1500) @(posedge clk_in);
      check("doze ignored", {6'h00, awake, irq}, 8'h02);
      i_host.wr(pmc_pkg::OFS_MOTION_CFG, 8'h10);
      k = 0;
      while (awake !== 1'b0 && k < 2000)
      begin
         @(negedge clk_in);
         k++;
      end
      @(posedge clk_in);
      check("doze entry", {7'h00, 1'(k < 8)}, 8'h01);
      settle();
      check("doze wake mode", {6'h00, wake_mode, irq}, 8'h03);
      rchk("doze status", pmc_pkg::OFS_IRQ_STATUS, 8'h01);
      period(n);
      check("doze rate", 8'(n / 100), 8'h08);
      i_host.wr(pmc_pkg::OFS_IRQ_ENABLE, 8'h00);
      settle();
      check("irq masked", {7'h00, irq}, 8'h00);
      i_host.wr(pmc_pkg::OFS_IRQ_CLEAR, 8'h01);
      i_host.wr(pmc_pkg::OFS_IRQ_ENABLE, 8'h01);
      settle();
      check("irq cleared", {7'h00, irq}, 8'h00);
      inactive_in <= 1'b0;
      active_in <= 1'b1;
      settle();
      active_in <= 1'b0;
      check("woken", {7'h00, awake}, 8'h01);
      rchk("woke status", pmc_pkg::OFS_IRQ_STATUS, 8'h02);
      $display("test doze done");
      finish_test();
   end
endmodule
`default_nettype wire
